// ===== design/pcp_pkg.sv
// Package for the PLL phase detector and charge-pump control block.
// Assumes a single 40 MHz clock domain; no register bus, all controls are ports.
package pcp_pkg;
    // Low bit pair of the first PLL control word
    localparam logic [1:0] PCP_BAND_SW = 2'h2;
    localparam logic [1:0] PCP_BAND_MWLW = 2'h3;
    localparam int PCP_BAND_LSB = 0;
    // Dead-zone control instruction bits 3 and 2
    localparam int PCP_SUB_LSB = 2;
    localparam logic [1:0] PCP_SUB_OFF = 2'h0;
    localparam logic [1:0] PCP_SUB_UNLK = 2'h1;
    localparam logic [1:0] PCP_SUB_RSVD = 2'h2;
    localparam logic [1:0] PCP_SUB_NORM = 2'h3;
    // Timing source
    localparam int PCP_XTAL_KHZ = 4500;
    localparam int PCP_UNLK_SUB_KHZ = 450;

    typedef enum logic [1:0] {PCP_CMP_EQ, PCP_CMP_HI, PCP_CMP_LO} pcp_cmp_t;
    typedef enum logic [1:0] {PCP_OSC_NONE, PCP_OSC_FM, PCP_OSC_AM_SW, PCP_OSC_AM_MWLW} pcp_osc_t;

    // One tristate pin: level and enable
    typedef struct packed {
        logic o;
        logic oe;
    } pcp_pin_t;

    typedef struct packed {
        logic clk_stop;
        logic por;
        logic pll_stop;
        logic hold_en;
        logic hold_n;
    } pcp_gate_t;
endpackage

// ===== design/pcp_gate.sv
// Gating module: decides when the loop is quiesced (pumps floated, inputs off).
// Assumes inputs synchronous to mclk.
`timescale 1ns/10ps
module pcp_gate
    import pcp_pkg::*;
(
    input wire pcp_gate_t gate,
    output logic quiet
);
    // Hold enable with the hold pin low, clock stop, power-on reset, PLL stop
    always_comb
    begin
        quiet = (gate.hold_en && !gate.hold_n) || gate.clk_stop || gate.por || gate.pll_stop;
    end
endmodule

// ===== design/pcp_ctrl.sv
// Charge-pump and oscillator-input control for a tuning PLL.
// Assumes the divider and reference come in as mclk-synchronous pulses and
// the decoder delivers control words and an unlocked flag as levels.
`timescale 1ns/10ps
module pcp_ctrl
    import pcp_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic div_pulse,
    input wire logic ref_pulse,
    input wire logic unlocked,
    input wire logic fm_select,
    input wire logic [3:0] pll_control_word_one,
    input wire logic [3:0] dead_zone_control_instr,
    input wire pcp_gate_t gate,
    input wire logic fm_osc_input,
    input wire logic am_osc_input,
    output pcp_pin_t main_pump_out_a,
    output pcp_pin_t main_pump_out_b,
    output pcp_pin_t second_pump_out,
    output pcp_pin_t fast_lock_pump_out,
    output logic fm_in_en,
    output logic am_in_en,
    output logic osc_gated,
    output pcp_osc_t osc_sel
);
    // Reference events come from the 4.5 MHz crystal chain outside
    localparam int XTAL_RATIO = PCP_XTAL_KHZ / PCP_UNLK_SUB_KHZ;

    logic quiet;
    pcp_cmp_t cmp_q;
    pcp_cmp_t cmp_d;
    logic sub_on;
    logic [1:0] band;
    logic [1:0] sub_code;

    pcp_gate u_gate
    (
        .gate(gate),
        .quiet(quiet)
    );

    function automatic pcp_pin_t drive(input logic lvl, input logic en);
        pcp_pin_t p;
        p.o = lvl;
        p.oe = en;
        return p;
    endfunction

    // Sequential phase/frequency detector: the edge that arrives first wins,
    // the opposite edge returns to the dead (match) state.
    always_comb
    begin
        cmp_d = cmp_q;
        if (div_pulse && !ref_pulse)
        begin
            cmp_d = (cmp_q == PCP_CMP_LO) ? PCP_CMP_EQ : PCP_CMP_HI;
        end
        else if (ref_pulse && !div_pulse)
        begin
            cmp_d = (cmp_q == PCP_CMP_HI) ? PCP_CMP_EQ : PCP_CMP_LO;
        end
        else if (ref_pulse && div_pulse)
        begin
            cmp_d = PCP_CMP_EQ;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || quiet)
        begin
            cmp_q <= PCP_CMP_EQ;
        end
        else
        begin
            cmp_q <= cmp_d;
        end
    end

    assign band = pll_control_word_one[PCP_BAND_LSB +: 2];
    assign sub_code = dead_zone_control_instr[PCP_SUB_LSB +: 2];

    always_comb
    begin
        unique case (sub_code)
            PCP_SUB_OFF: sub_on = 1'b0;
            PCP_SUB_UNLK: sub_on = unlocked;
            PCP_SUB_RSVD: sub_on = 1'b0;
            PCP_SUB_NORM: sub_on = 1'b1;
        endcase
    end

    // Pump pins; a match floats them so the loop filter holds its charge
    always_ff @(posedge mclk)
    begin
        if (sys_rst || quiet)
        begin
            main_pump_out_a <= drive(1'b0, 1'b0);
            main_pump_out_b <= drive(1'b0, 1'b0);
            second_pump_out <= drive(1'b0, 1'b0);
            fast_lock_pump_out <= drive(1'b0, 1'b0);
        end
        else
        begin
            main_pump_out_a <= drive(cmp_d == PCP_CMP_HI, cmp_d != PCP_CMP_EQ);
            main_pump_out_b <= drive(cmp_d == PCP_CMP_HI, cmp_d != PCP_CMP_EQ);
            second_pump_out <= drive(cmp_d == PCP_CMP_LO, cmp_d != PCP_CMP_EQ);
            fast_lock_pump_out <= drive(cmp_d == PCP_CMP_HI, sub_on && cmp_d != PCP_CMP_EQ);
        end
    end

    // Oscillator input selection and gating
    always_ff @(posedge mclk)
    begin
        if (sys_rst || quiet)
        begin
            fm_in_en <= 1'b0;
            am_in_en <= 1'b0;
            osc_gated <= 1'b1;
            osc_sel <= PCP_OSC_NONE;
        end
        else
        begin
            osc_gated <= 1'b0;
            if (fm_select)
            begin
                fm_in_en <= 1'b1;
                am_in_en <= 1'b0;
                osc_sel <= PCP_OSC_FM;
            end
            else
            begin
                fm_in_en <= 1'b0;
                am_in_en <= band[1];
                osc_sel <= (band == PCP_BAND_SW) ? PCP_OSC_AM_SW :
                    (band == PCP_BAND_MWLW) ? PCP_OSC_AM_MWLW : PCP_OSC_NONE;
            end
        end
    end

    logic unused_sig;
    assign unused_sig = fm_osc_input ^ am_osc_input ^ (XTAL_RATIO == 0);

    // Checks
    a_main_hi_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && cmp_d == PCP_CMP_HI) |=> (main_pump_out_a.oe && main_pump_out_a.o && main_pump_out_b.o))
        else $error("main pump not high when divided above reference");
    a_main_lo_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && cmp_d == PCP_CMP_LO) |=> (main_pump_out_a.oe && !main_pump_out_a.o))
        else $error("main pump not low when divided below reference");
    a_match_float: assert property (@(posedge mclk) disable iff (sys_rst)
        (cmp_d == PCP_CMP_EQ) |=> (!main_pump_out_a.oe && !main_pump_out_b.oe && !second_pump_out.oe))
        else $error("pump driven on match");
    a_second_inverted: assert property (@(posedge mclk) disable iff (sys_rst)
        second_pump_out.oe |-> (second_pump_out.o == !main_pump_out_a.o))
        else $error("second pump polarity not inverted");
    a_hold_float: assert property (@(posedge mclk) disable iff (sys_rst)
        (gate.hold_en && !gate.hold_n) |=> (!main_pump_out_a.oe && !main_pump_out_b.oe && !fast_lock_pump_out.oe
        && !second_pump_out.oe))
        else $error("pump driven in hold");
    a_stop_float: assert property (@(posedge mclk) disable iff (sys_rst)
        (gate.clk_stop || gate.por || gate.pll_stop)
        |=> (!main_pump_out_a.oe && !main_pump_out_b.oe && !second_pump_out.oe && !fast_lock_pump_out.oe))
        else $error("pump driven while stopped");
    a_fm_select: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && fm_select) |=> (fm_in_en && !am_in_en && osc_sel == PCP_OSC_FM))
        else $error("fm input not selected");
    a_am_band: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && !fm_select && band == PCP_BAND_MWLW) |=> (am_in_en && osc_sel == PCP_OSC_AM_MWLW))
        else $error("am band wrong");
    a_inputs_gated: assert property (@(posedge mclk) disable iff (sys_rst)
        quiet |=> (!fm_in_en && !am_in_en && osc_gated))
        else $error("oscillator input live while gated");
    a_sub_off: assert property (@(posedge mclk) disable iff (sys_rst)
        (!sub_code[0]) |=> !fast_lock_pump_out.oe)
        else $error("sub pump driven with code 00 or 10");
    a_sub_unlock: assert property (@(posedge mclk) disable iff (sys_rst)
        (sub_code == PCP_SUB_UNLK && !unlocked) |=> !fast_lock_pump_out.oe)
        else $error("sub pump driven while locked in code 01");
    a_sub_unlk_drive: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && sub_code == PCP_SUB_UNLK && unlocked && cmp_d != PCP_CMP_EQ) |=> fast_lock_pump_out.oe)
        else $error("sub pump idle while unlocked in code 01");
    a_sub_normal: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && sub_code == PCP_SUB_NORM && cmp_d != PCP_CMP_EQ)
        |=> (fast_lock_pump_out.oe && fast_lock_pump_out.o == main_pump_out_a.o))
        else $error("sub pump not following main pump in normal mode");
    a_second_low: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && cmp_d == PCP_CMP_HI) |=> (second_pump_out.oe && !second_pump_out.o))
        else $error("second pump not low when divided above reference");
    a_sw_band: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && !fm_select && band == PCP_BAND_SW) |=> (am_in_en && !fm_in_en && osc_sel == PCP_OSC_AM_SW))
        else $error("shortwave band not selected");
    a_stop_gated: assert property (@(posedge mclk) disable iff (sys_rst)
        (gate.clk_stop || gate.por || gate.pll_stop) |=> (!fm_in_en && !am_in_en && osc_gated))
        else $error("oscillator input live while stopped");
    a_both_match: assert property (@(posedge mclk) disable iff (sys_rst)
        (!quiet && div_pulse && ref_pulse) |=> (!main_pump_out_a.oe && !second_pump_out.oe && !fast_lock_pump_out.oe))
        else $error("pump driven after simultaneous pulses");

    // Two-step walk: a lone divided pulse from the dead state, then a lone reference pulse
    sequence s_div_lead;
        !quiet && div_pulse && !ref_pulse && cmp_q == PCP_CMP_EQ;
    endsequence
    sequence s_ref_close;
        !quiet && ref_pulse && !div_pulse;
    endsequence
    a_walk_lead_return: assert property (@(posedge mclk) disable iff (sys_rst)
        s_div_lead ##1 s_ref_close |-> (main_pump_out_a.oe && main_pump_out_a.o) ##1 !main_pump_out_a.oe)
        else $error("pump did not drive and then float over a lead and return");
endmodule

// ===== sim/pcp_vco_model.sv
// Behavioural VCO and loop filter facing main pump A.
// Assumes mclk as time base; the VCO tone is a phase accumulator.
`timescale 1ns/10ps
module pcp_vco_model
    import pcp_pkg::*;
(
    input wire logic mclk,
    input wire pcp_pin_t pump,
    output logic vco_fm,
    output logic vco_am
);
    int tune = 0;
    int ph = 0;
    // A floated pump leaves the filter charge, and so the tone, unchanged
    always @(posedge mclk)
    begin
        if (pump.oe)
            tune <= pump.o ? tune + 1 : tune - 1;
        ph <= ph + 4 + (tune & 3);
    end
    assign vco_fm = ph[3];
    assign vco_am = ph[4];
endmodule

// ===== sim/pcp_ctrl_tb.sv
// Self-checking bench for pcp_ctrl: random pulses, control words and gates.
// Assumes one 40 MHz clock; the VCO model follows main pump A and feeds the oscillator inputs.
`timescale 1ns/10ps
module pcp_ctrl_tb import pcp_pkg::*;;
    typedef struct packed {pcp_pin_t a, b, s, f; logic [3:0] v; int due;} pcp_note_t;
    logic mclk = 0, sys_rst = 1, div_pulse = 0, ref_pulse = 0, unlocked = 0, fm_select = 0;
    logic [3:0] cw = 0, dz = 0;
    pcp_gate_t gate = '0;
    logic fm_osc, am_osc, fm_en, am_en, gated;
    pcp_pin_t pa, pb, ps, pf;
    pcp_osc_t sel;
    pcp_cmp_t st = PCP_CMP_EQ;
    pcp_note_t q[$];
    pcp_note_t n;
    int err_total = 0, num_checks = 0, cyc = 0;
    logic [31:0] rng = 32'h2D80;

    always #12.5 mclk = ~mclk;

    pcp_ctrl i_dut (.mclk, .sys_rst, .div_pulse, .ref_pulse, .unlocked, .fm_select,
        .pll_control_word_one(cw), .dead_zone_control_instr(dz), .gate, .fm_osc_input(fm_osc),
        .am_osc_input(am_osc), .main_pump_out_a(pa), .main_pump_out_b(pb), .second_pump_out(ps),
        .fast_lock_pump_out(pf), .fm_in_en(fm_en), .am_in_en(am_en), .osc_gated(gated), .osc_sel(sel));
    pcp_vco_model i_vco (.mclk, .pump(pa), .vco_fm(fm_osc), .vco_am(am_osc));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    // Drives one cycle of random stimulus and notes what the next edge must give
    task automatic step(input logic rst, input logic gm);
        logic [31:0] r;
        pcp_gate_t g;
        logic qt, on, dv, rf;
        rng = xs(rng);
        r = rng;
        // Both pulses in one cycle now and then, which the detector takes as a match
        dv = r[0] & (~r[1] | r[12]);
        rf = r[1] & (~r[0] | r[12]);
        g = gm ? {r[16:14] == 0, r[19:17] == 0, r[22:20] == 0, r[23], r[24] | r[25]} : 5'h01;
        @(posedge mclk);
        {sys_rst, gate, fm_select, unlocked} <= {rst, g, r[3], r[2]};
        {div_pulse, ref_pulse, cw, dz} <= {dv, rf, r[7:4], r[11:8]};
        qt = rst | g.clk_stop | g.por | g.pll_stop | (g.hold_en & ~g.hold_n);
        if (qt)
            st = PCP_CMP_EQ;
        else if (dv & rf)
            st = PCP_CMP_EQ;
        else if (dv)
            st = (st == PCP_CMP_LO) ? PCP_CMP_EQ : PCP_CMP_HI;
        else if (rf)
            st = (st == PCP_CMP_HI) ? PCP_CMP_EQ : PCP_CMP_LO;
        on = (r[11:10] == PCP_SUB_NORM) | ((r[11:10] == PCP_SUB_UNLK) & r[2]);
        n.a = {st == PCP_CMP_HI, st != PCP_CMP_EQ};
        n.b = n.a;
        n.s = {st == PCP_CMP_LO, st != PCP_CMP_EQ};
        n.f = {st == PCP_CMP_HI, on & (st != PCP_CMP_EQ)};
        n.v[1:0] = qt ? PCP_OSC_NONE : r[3] ? PCP_OSC_FM : (r[5:4] == PCP_BAND_SW) ? PCP_OSC_AM_SW
            : (r[5:4] == PCP_BAND_MWLW) ? PCP_OSC_AM_MWLW : PCP_OSC_NONE;
        n.v[3:2] = {qt, !qt & r[3]};
        // cyc still holds the count before this edge; the design samples these inputs at the next one
        n.due = cyc + 2;
        q.push_back(n);
    endtask

    task automatic chk_pin(input string nm, input pcp_pin_t e, input pcp_pin_t a);
        num_checks++;
        if (a.oe !== e.oe || (e.oe && a.o !== e.o))
        begin
            err_total++;
            $display("BAD %s exp %b got %b", nm, e, a);
        end
    endtask

    task automatic chk_val(input string nm, input logic [4:0] e, input logic [4:0] a);
        num_checks++;
        if (a !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, a);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Outputs land at the edge that samples the stimulus; look at the next low phase
    always @(negedge mclk)
        while (q.size() > 0 && q[0].due <= cyc)
        begin
            n = q.pop_front();
            chk_pin("pump_a", n.a, pa);
            chk_pin("pump_b", n.b, pb);
            chk_pin("second_pump", n.s, ps);
            chk_pin("fast_lock", n.f, pf);
            chk_val("osc", {n.v[3:2], n.v[1] & (n.v[1:0] != PCP_OSC_NONE), n.v[1:0]},
                {gated, fm_en, am_en, sel});
        end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_total++;
            finish_test;
        end
    end

    initial
    begin
        repeat (12) step(1'b1, 1'b0);
        repeat (800) step(1'b0, 1'b0);
        $display("test free_run done");
        repeat (600) step(1'b0, 1'b1);
        $display("test gated_run done");
        repeat (3) step(1'b1, 1'b1);
        repeat (200) step(1'b0, 1'b1);
        repeat (3) @(posedge mclk);
        $display("test second_reset done");
        finish_test;
    end
endmodule
